// *** qepv_top.sv ***
// Quadrature encoder position and velocity block with register port and interrupt.
// What this block does
// - Velocity is pulses per fixed timer period.
// - Velocity runs only while position capture enabled.
// - Phase mode derives direction from edge order.
// - Step/direction mode counts step edges.
// - Option counts first channel or both channels.
// - Swap exchanges channels before decoding.
// - Optional index reset gives absolute position.
// - Maximum position limits and reloads on reverse.
// - Running and latched velocity counts readable.
// - Last direction kept, bits 31:1 read 0 (forward) or -1 (reverse).
// - Simultaneous channel change in phase mode sets error indicator.
// - Four individually maskable interrupt events.
// - Clearing a source deasserts it.
// - Only enabled sources drive the interrupt line.
// - Power-of-two predivider, nonzero period, save, restart.
// - Position write loads counter, counting continues.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module qepv_top
    import qepv_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic encoderChannelFirst,
    input wire logic encoderChannelSecond,
    input wire logic encoderIndex,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic irq
);
    typedef struct packed {
        logic [4:0] ctrl;
        logic [31:0] maxPos;
        logic [31:0] pos;
        logic velEn;
        logic [2:0] velDiv;
        logic [31:0] velPer;
        logic lastFwd;
        logic errFlag;
        qepv_irq_t intEn;
        qepv_irq_t intRaw;
        logic [31:0] rdata;
    } qepv_top_t;
    qepv_top_t st;
    qepv_top_t next_st;
    qepv_irq_t events;
    qepv_irq_t clrMask;
    logic enabled;
    logic [31:0] velRun;
    logic [31:0] velVal;
    logic velExpire;
    logic [31:0] rdMux;
    qepv_step_if stepBus ();

    assign enabled = st.ctrl[QEPV_CTRL_EN_BIT];

    // Decoder sees the configuration directly; software sets it before enabling.
    qepv_decoder u_dec (
        .clk(clk),
        .rst(rst),
        .chFirst(encoderChannelFirst),
        .chSecond(encoderChannelSecond),
        .chIndex(encoderIndex),
        .swap(st.ctrl[QEPV_CTRL_SWAP_BIT]),
        .clkDir(st.ctrl[QEPV_CTRL_CLKDIR_BIT]),
        .bothEdges(st.ctrl[QEPV_CTRL_BOTH_BIT]),
        .stepOut(stepBus)
    );

    // Velocity unit runs only with the block and velocity both enabled.
    qepv_velocity #(.WIDTH(32)) u_vel (
        .clk(clk),
        .rst(rst),
        .run(enabled && st.velEn),
        .step(stepBus.step),
        .divSel(st.velDiv),
        .period(st.velPer),
        .running(velRun),
        .velocity(velVal),
        .expire(velExpire)
    );

    // Event sources, all forced to zero while the block is disabled.
    always_comb begin
        events = '0;
        if (enabled) begin
            events[QEPV_INT_INDEX_BIT] = stepBus.indexSeen;
            events[QEPV_INT_TIMER_BIT] = velExpire;
            events[QEPV_INT_DIR_BIT] = stepBus.step && (stepBus.dirFwd != st.lastFwd);
            events[QEPV_INT_ERR_BIT] = stepBus.phaseErr;
        end
    end

    assign clrMask = (regWr && regAddr == QEPV_INTCLR_OFS) ? regWdata[QEPV_NUM_INT-1:0] : '0;

    // Read data multiplexer.
    always_comb begin
        rdMux = 32'h00000000;
        if (regAddr == QEPV_CTRL_OFS) begin
            rdMux = {27'h0000000, st.ctrl};
        end else if (regAddr == QEPV_MAXPOS_OFS) begin
            rdMux = st.maxPos;
        end else if (regAddr == QEPV_POS_OFS) begin
            rdMux = st.pos;
        end else if (regAddr == QEPV_VELCFG_OFS) begin
            rdMux = {25'h0000000, st.velDiv, 3'h0, st.velEn};
        end else if (regAddr == QEPV_VELPER_OFS) begin
            rdMux = st.velPer;
        end else if (regAddr == QEPV_VELRUN_OFS) begin
            rdMux = velRun;
        end else if (regAddr == QEPV_VELVAL_OFS) begin
            rdMux = velVal;
        end else if (regAddr == QEPV_STAT_OFS) begin
            // Bit 0 error, bits 31:1 direction as signed 0 (forward) or -1 (reverse).
            rdMux = {st.lastFwd ? 31'h00000000 : 31'h7FFFFFFF, st.errFlag};
        end else if (regAddr == QEPV_INTEN_OFS) begin
            rdMux = {28'h0000000, st.intEn};
        end else if (regAddr == QEPV_INTRAW_OFS) begin
            rdMux = {28'h0000000, st.intRaw};
        end else if (regAddr == QEPV_INTMSK_OFS) begin
            rdMux = {28'h0000000, st.intRaw & st.intEn};
        end
    end

    // Main next-state logic: registers, position counter and flags.
    always_comb begin
        next_st = st;
        next_st.rdata = regRd ? rdMux : 32'h00000000;
        if (regWr) begin
            if (regAddr == QEPV_CTRL_OFS) begin
                next_st.ctrl = regWdata[4:0];
            end else if (regAddr == QEPV_MAXPOS_OFS) begin
                next_st.maxPos = regWdata;
            end else if (regAddr == QEPV_VELCFG_OFS) begin
                next_st.velEn = regWdata[QEPV_VELCFG_EN_BIT];
                next_st.velDiv = regWdata[QEPV_VELCFG_DIV_LSB +: 3];
            end else if (regAddr == QEPV_VELPER_OFS) begin
                next_st.velPer = (regWdata == 32'h00000000) ? 32'h00000001 : regWdata;
            end else if (regAddr == QEPV_INTEN_OFS) begin
                next_st.intEn = regWdata[QEPV_NUM_INT-1:0];
            end else if (regAddr == QEPV_STAT_OFS) begin
                next_st.errFlag = st.errFlag & ~regWdata[0];
            end
        end
        if (enabled) begin
            if (stepBus.step) begin
                next_st.lastFwd = stepBus.dirFwd;
                if (stepBus.dirFwd) begin
                    next_st.pos = (st.pos >= st.maxPos) ? 32'h00000000 : st.pos + 32'h1;
                end else begin
                    next_st.pos = (st.pos == 32'h0) ? st.maxPos : st.pos - 32'h1;
                end
            end
            if (stepBus.indexSeen && st.ctrl[QEPV_CTRL_RSTIDX_BIT]) begin
                next_st.pos = st.lastFwd ? 32'h00000000 : st.maxPos;
            end
            if (stepBus.phaseErr) begin
                next_st.errFlag = 1'b1;
            end
        end
        if (regWr && regAddr == QEPV_POS_OFS) begin
            next_st.pos = regWdata;
        end
        // Set wins over a clear in the same cycle.
        next_st.intRaw = (st.intRaw & ~clrMask) | events;
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.maxPos <= QEPV_MAXPOS_RST;
            st.velPer <= QEPV_VELPER_RST;
            st.lastFwd <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign regRdata = st.rdata;
    assign irq = |(st.intRaw & st.intEn);

    chk_irq_masked: assert property (@(posedge clk) disable iff (rst)
        irq |-> |(st.intRaw & st.intEn)) else $error("Interrupt without enabled source.");
    chk_clear_works: assert property (@(posedge clk) disable iff (rst)
        (clrMask[0] && !events[0]) |=> !st.intRaw[0]) else $error("Clear ignored.");
    chk_event_sticky: assert property (@(posedge clk) disable iff (rst)
        events[1] |=> st.intRaw[1]) else $error("Timer event lost.");
    chk_pos_frozen: assert property (@(posedge clk) disable iff (rst)
        (!enabled && !regWr) |=> $stable(st.pos)) else $error("Position moved while off.");
    chk_pos_load: assert property (@(posedge clk) disable iff (rst)
        (regWr && regAddr == QEPV_POS_OFS) |=> st.pos == $past(regWdata))
        else $error("Position load failed.");
    chk_idx_fwd: assert property (@(posedge clk) disable iff (rst)
        (enabled && stepBus.indexSeen && st.ctrl[QEPV_CTRL_RSTIDX_BIT] && st.lastFwd && !regWr)
        |=> st.pos == 32'h0) else $error("Forward index did not zero.");
    chk_idx_rev: assert property (@(posedge clk) disable iff (rst)
        (enabled && stepBus.indexSeen && st.ctrl[QEPV_CTRL_RSTIDX_BIT] && !st.lastFwd && !regWr)
        |=> st.pos == $past(st.maxPos)) else $error("Reverse index did not load max.");
    chk_err_sets: assert property (@(posedge clk) disable iff (rst)
        (enabled && stepBus.phaseErr) |=> st.errFlag) else $error("Error flag not set.");
    chk_dir_kept: assert property (@(posedge clk) disable iff (rst)
        !stepBus.step |=> $stable(st.lastFwd)) else $error("Direction changed without step.");
    cov_irq: cover property (@(posedge clk) disable iff (rst) irq);
    cov_idx: cover property (@(posedge clk) disable iff (rst) events[0]);
    cov_rev: cover property (@(posedge clk) disable iff (rst) stepBus.step && !stepBus.dirFwd);
endmodule
`default_nettype wire

// *** qepv_pkg.sv ***
// Package with register map, field positions, reset values and types of the encoder block.
package qepv_pkg;
    // Register byte offsets.
    localparam logic [7:0] QEPV_CTRL_OFS = 8'h00;
    localparam logic [7:0] QEPV_MAXPOS_OFS = 8'h04;
    localparam logic [7:0] QEPV_POS_OFS = 8'h08;
    localparam logic [7:0] QEPV_VELCFG_OFS = 8'h0C;
    localparam logic [7:0] QEPV_VELPER_OFS = 8'h10;
    localparam logic [7:0] QEPV_VELRUN_OFS = 8'h14;
    localparam logic [7:0] QEPV_VELVAL_OFS = 8'h18;
    localparam logic [7:0] QEPV_STAT_OFS = 8'h1C;
    localparam logic [7:0] QEPV_INTEN_OFS = 8'h20;
    localparam logic [7:0] QEPV_INTRAW_OFS = 8'h24;
    localparam logic [7:0] QEPV_INTMSK_OFS = 8'h28;
    localparam logic [7:0] QEPV_INTCLR_OFS = 8'h2C;
    // Control and velocity configuration register field positions.
    localparam int QEPV_CTRL_EN_BIT = 0;
    localparam int QEPV_CTRL_BOTH_BIT = 1;
    localparam int QEPV_CTRL_RSTIDX_BIT = 2;
    localparam int QEPV_CTRL_CLKDIR_BIT = 3;
    localparam int QEPV_CTRL_SWAP_BIT = 4;
    localparam int QEPV_VELCFG_EN_BIT = 0;
    localparam int QEPV_VELCFG_DIV_LSB = 4;
    // Interrupt bit positions.
    localparam int QEPV_INT_INDEX_BIT = 0;
    localparam int QEPV_INT_TIMER_BIT = 1;
    localparam int QEPV_INT_DIR_BIT = 2;
    localparam int QEPV_INT_ERR_BIT = 3;
    // Reset values.
    localparam logic [31:0] QEPV_MAXPOS_RST = 32'hFFFFFFFF;
    localparam logic [31:0] QEPV_VELPER_RST = 32'h00000001;
    // Width of the event group.
    localparam int QEPV_NUM_INT = 4;
    typedef logic [QEPV_NUM_INT-1:0] qepv_irq_t;
endpackage

// *** qepv_step_if.sv ***
// Interface carrying decoded steps from the decoder to the core.
`timescale 1ns/10ps
`default_nettype none
interface qepv_step_if;
    logic step;
    logic dirFwd;
    logic phaseErr;
    logic indexSeen;
    modport src (output step, output dirFwd, output phaseErr, output indexSeen);
    modport dst (input step, input dirFwd, input phaseErr, input indexSeen);
endinterface
`default_nettype wire

// *** qepv_decoder.sv ***
// Input synchroniser, swap and quadrature or step/direction decoder.
`timescale 1ns/10ps
`default_nettype none
module qepv_decoder
    import qepv_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic chFirst,
    input wire logic chSecond,
    input wire logic chIndex,
    input wire logic swap,
    input wire logic clkDir,
    input wire logic bothEdges,
    qepv_step_if.src stepOut
);
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prev;
        logic step;
        logic dirFwd;
        logic err;
        logic idx;
    } qepv_dec_t;
    qepv_dec_t st;
    qepv_dec_t next_st;
    logic a;
    logic b;
    logic pa;
    logic pb;
    logic chgA;
    logic chgB;

    // Swap channels before any decoding; the prev stage holds swapped values too.
    assign a = swap ? st.sync2[1] : st.sync2[0];
    assign b = swap ? st.sync2[0] : st.sync2[1];
    assign pa = st.prev[0];
    assign pb = st.prev[1];
    assign chgA = a ^ pa;
    assign chgB = b ^ pb;

    // Decode the synchronised pins into one-cycle step, error and index pulses and a held direction.
    always_comb begin
        next_st = st;
        next_st.sync1 = {chIndex, chSecond, chFirst};
        next_st.sync2 = st.sync1;
        next_st.prev = {st.sync2[2], b, a};
        next_st.step = 1'b0;
        next_st.err = 1'b0;
        next_st.idx = st.sync2[2] & ~st.prev[2];
        if (clkDir) begin
            if (chgA && a) begin
                next_st.step = 1'b1;
                next_st.dirFwd = b;
            end
        end else if (chgA && chgB) begin
            next_st.err = 1'b1;
        end else if (chgA) begin
            next_st.step = 1'b1;
            next_st.dirFwd = (a != b);
        end else if (chgB && bothEdges) begin
            next_st.step = 1'b1;
            next_st.dirFwd = (a == b);
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.dirFwd <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign stepOut.step = st.step;
    assign stepOut.dirFwd = st.dirFwd;
    assign stepOut.phaseErr = st.err;
    assign stepOut.indexSeen = st.idx;

    chk_err_no_step: assert property (@(posedge clk) disable iff (rst)
        st.err |-> !st.step) else $error("Step with phase error.");
endmodule
`default_nettype wire

// *** qepv_velocity.sv ***
// Velocity unit: predivider, period timer and pulse accumulator.
`timescale 1ns/10ps
`default_nettype none
module qepv_velocity
    import qepv_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic step,
    input wire logic [2:0] divSel,
    input wire logic [WIDTH-1:0] period,
    output logic [WIDTH-1:0] running,
    output logic [WIDTH-1:0] velocity,
    output logic expire
);
    typedef struct packed {
        logic [6:0] pre;
        logic [WIDTH-1:0] tmr;
        logic [WIDTH-1:0] acc;
        logic [WIDTH-1:0] vel;
        logic exp;
    } qepv_vel_t;
    qepv_vel_t st;
    qepv_vel_t next_st;
    logic divStep;
    logic [6:0] divMask;

    // Predivide by a power of two from 1 to 128.
    assign divMask = 7'(({1'b0, 7'h00} | 8'h01) << divSel) - 7'h01;
    assign divStep = step && ((st.pre & divMask) == divMask);

    // Count pulses over each period, then save and restart the accumulator.
    always_comb begin
        next_st = st;
        next_st.exp = 1'b0;
        if (run) begin
            if (step) begin
                next_st.pre = st.pre + 7'h01;
            end
            if (st.tmr + 1'b1 >= period) begin
                next_st.tmr = '0;
                next_st.vel = st.acc + WIDTH'(divStep);
                next_st.acc = '0;
                next_st.exp = 1'b1;
            end else begin
                next_st.tmr = st.tmr + 1'b1;
                next_st.acc = st.acc + WIDTH'(divStep);
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign running = st.acc;
    assign velocity = st.vel;
    assign expire = st.exp;

    chk_vel_frozen: assert property (@(posedge clk) disable iff (rst)
        !run |=> $stable(st.acc)) else $error("Accumulator moved while stopped.");
endmodule
`default_nettype wire

// *** qepv_enc_model.sv ***
// Behavioural rotary encoder with index pulse that drives the block's input pins.
`timescale 1ns/10ps
`default_nettype none
module qepv_enc_model (
    input wire logic clk,
    output logic chFirst,
    output logic chSecond,
    output logic index
);
    logic [1:0] q = 2'h0;

    // All pins rest low until the bench moves the shaft.
    initial begin
        chFirst = 1'b0;
        chSecond = 1'b0;
        index = 1'b0;
    end

    // Quadrature step; the first channel leads going forward, a move of 2 flips both at once.
    task automatic quad(input int dir, input int gap);
        q = q + 2'(dir);
        @(posedge clk);
        chFirst <= q[0] ^ q[1];
        chSecond <= q[1];
        repeat (gap) @(posedge clk);
    endtask

    // Step pulse on one pin with the direction level on the other, then both pins rest low.
    task automatic stepDir(input logic fwd, input logic sw, input int gap);
        @(posedge clk);
        chFirst <= sw ? fwd : 1'b0;
        chSecond <= sw ? 1'b0 : fwd;
        repeat (gap) @(posedge clk);
        if (sw) begin
            chSecond <= 1'b1;
        end else begin
            chFirst <= 1'b1;
        end
        repeat (gap) @(posedge clk);
        chFirst <= 1'b0;
        chSecond <= 1'b0;
        q = 2'h0;
        repeat (gap) @(posedge clk);
    endtask

    // Index pulse three clocks wide.
    task automatic pulse(input int gap);
        @(posedge clk);
        index <= 1'b1;
        repeat (3) @(posedge clk);
        index <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the encoder block against a behavioural model.
`timescale 1ns/10ps
`default_nettype none
module tb
    import qepv_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic irq, encoder_channel_first, encoder_channel_second, chI;
    logic en = 1'b0, both = 1'b0, rix = 1'b0, cd = 1'b0, sw = 1'b0;
    logic [3:0] mRaw = 4'h0;
    logic [3:0] mEn = 4'h0;
    logic [31:0] lfsr = 32'h00016838;
    longint mPos = 0;
    longint mMax = 0;
    int mDir = 1;
    int fail_count = 0;
    int n_compared = 0;
    logic [7:0] ra [7] = '{8'h30, QEPV_CTRL_OFS, QEPV_MAXPOS_OFS, QEPV_POS_OFS,
        QEPV_VELPER_OFS, QEPV_STAT_OFS, QEPV_INTRAW_OFS};
    logic [31:0] rv [7] = '{32'h0, 32'h0, QEPV_MAXPOS_RST, 32'h0, QEPV_VELPER_RST, 32'h0, 32'h0};

    qepv_top qepv_top_i (.clk(clk), .rst(rst), .encoderChannelFirst(encoder_channel_first),
        .encoderChannelSecond(encoder_channel_second), .encoderIndex(chI), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
    qepv_enc_model qepv_enc_model_i (.clk(clk), .chFirst(encoder_channel_first), .chSecond(encoder_channel_second), .index(chI));

    // Clock of 8 ns period.
    always #4 clk = ~clk;

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // Register write and read; read data are taken in the one cycle they stand.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
        @(posedge clk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask

    // Mode changes are made with the block off, then it is enabled: a swap or mode switch
    // can make both decoded channels jump at once, which must not count as a move.
    task automatic cfg(input logic [4:0] v);
        {sw, cd, rix, both, en} = v;
        wr(QEPV_CTRL_OFS, {27'h0, v & 5'h1E});
        repeat (4) @(posedge clk);
        wr(QEPV_CTRL_OFS, {27'h0, v});
    endtask

    task automatic setEn(input logic [3:0] m);
        mEn = m;
        wr(QEPV_INTEN_OFS, {28'h0, m});
    endtask

    task automatic clr(input logic [3:0] m);
        mRaw = mRaw & ~m;
        wr(QEPV_INTCLR_OFS, {28'h0, m});
    endtask

    // Expected effect of one counted step, with wrap at the maximum position.
    task automatic mov(input int e);
        if (e != mDir) mRaw[2] = 1'b1;
        mDir = e;
        if (e > 0) mPos = (mPos >= mMax) ? 0 : mPos + 1;
        else mPos = (mPos == 0) ? mMax : mPos - 1;
    endtask

    // Quadrature steps, each followed by a position compare.
    task automatic walk(input int n, input logic fwd);
        int d;
        logic a0;
        for (int i = 0; i < n; i++) begin
            lfsr = lfsrNext(lfsr);
            d = (fwd || lfsr[0]) ? 1 : -1;
            a0 = sw ? encoder_channel_second : encoder_channel_first;
            qepv_enc_model_i.quad(d, lfsr[1] ? 6 : 12);
            if (en && (both || a0 !== (sw ? encoder_channel_second : encoder_channel_first))) mov(sw ? -d : d);
            rc(QEPV_POS_OFS, mPos[31:0], "position");
        end
    endtask

    task automatic idxp();
        qepv_enc_model_i.pulse(8);
        if (en) mRaw[0] = 1'b1;
        if (en && rix) mPos = (mDir > 0) ? 0 : mMax;
    endtask

    task automatic ichk();
        rc(QEPV_INTRAW_OFS, {28'h0, mRaw}, "intRaw");
        rc(QEPV_INTMSK_OFS, {28'h0, mRaw & mEn}, "intMasked");
        @(negedge clk);
        chk("irq", {31'h0, |(mRaw & mEn)}, {31'h0, irq});
        @(posedge clk);
    endtask

    task automatic wirq();
        int k;
        k = 0;
        @(negedge clk);
        while (irq !== 1'b1 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk("timerIrq", 32'h1, {31'h0, irq});
        @(posedge clk);
    endtask

    // One velocity period after a timer expiry holds the pulses of n steps.
    task automatic vel(input logic [2:0] dv, input int n);
        wr(QEPV_VELCFG_OFS, {25'h0, dv, 4'h1});
        wirq();
        clr(4'h2);
        walk(n, 1'b1);
        rc(QEPV_VELRUN_OFS, 32'(n >> dv), "velRunning");
        wirq();
        clr(4'h2);
        rc(QEPV_VELVAL_OFS, 32'(n >> dv), "velocity");
    endtask

    task automatic done(input string n);
        $display("Test %s finished", n);
    endtask

    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        final_report();
    end

    // Main sequence.
    initial begin
        logic [31:0] d;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(8'h30, lfsr);
        for (int i = 0; i < 7; i++) rc(ra[i], rv[i], "resetValue");
        ichk();
        done("reset");
        lfsr = lfsrNext(lfsr);
        mMax = 6 + lfsr[3:0];
        wr(QEPV_MAXPOS_OFS, mMax[31:0]);
        setEn(4'hF);
        cfg(5'h03);
        walk(40, 1'b0);
        ichk();
        setEn(4'h0);
        ichk();
        clr(4'hF);
        setEn(4'hF);
        ichk();
        done("phase");
        idxp();
        rc(QEPV_POS_OFS, mPos[31:0], "noIndexReset");
        cfg(5'h07);
        walk(2, 1'b1);
        idxp();
        rc(QEPV_POS_OFS, mPos[31:0], "indexForward");
        qepv_enc_model_i.quad(1, 6);
        mov(1);
        qepv_enc_model_i.quad(-1, 6);
        mov(-1);
        idxp();
        rc(QEPV_POS_OFS, mPos[31:0], "indexReverse");
        rc(QEPV_STAT_OFS, 32'hFFFFFFFE, "dirReverse");
        ichk();
        clr(4'hF);
        done("index");
        cfg(5'h13);
        walk(12, 1'b0);
        cfg(5'h01);
        walk(8, 1'b1);
        rc(QEPV_STAT_OFS, 32'h0, "dirForward");
        done("swap and edges");
        for (int s = 0; s < 2; s++) begin
            cfg(s ? 5'h1B : 5'h0B);
            for (int i = 0; i < 6; i++) begin
                lfsr = lfsrNext(lfsr);
                qepv_enc_model_i.stepDir(lfsr[0], s[0], 6);
                mov(lfsr[0] ? 1 : -1);
                rc(QEPV_POS_OFS, mPos[31:0], "stepPos");
            end
        end
        done("step direction");
        cfg(5'h03);
        lfsr = lfsrNext(lfsr);
        mPos = lfsr[2:0] % 7;
        wr(QEPV_POS_OFS, mPos[31:0]);
        walk(3, 1'b0);
        ichk();
        clr(4'hF);
        cfg(5'h02);
        wr(QEPV_VELCFG_OFS, 32'h00000001);
        walk(4, 1'b1);
        idxp();
        rc(QEPV_VELRUN_OFS, 32'h0, "velFrozen");
        ichk();
        done("disable");
        cfg(5'h03);
        wr(QEPV_VELPER_OFS, 32'h0);
        rc(QEPV_VELPER_OFS, 32'h1, "velPeriod");
        wr(QEPV_VELPER_OFS, 32'h00000190);
        setEn(4'h2);
        clr(4'hF);
        vel(3'h0, 5);
        vel(3'h2, 8);
        vel(3'h3, 16);
        wr(QEPV_VELCFG_OFS, 32'h0);
        clr(4'hF);
        setEn(4'hF);
        done("velocity");
        qepv_enc_model_i.quad(2, 8);
        rd(QEPV_STAT_OFS, d);
        chk("errFlag", 32'h1, {31'h0, d[0]});
        rd(QEPV_INTRAW_OFS, d);
        chk("errEvent", 32'h1, {31'h0, d[3]});
        wr(QEPV_STAT_OFS, 32'h1);
        rd(QEPV_STAT_OFS, d);
        chk("errCleared", 32'h0, {31'h0, d[0]});
        clr(4'h8);
        rd(QEPV_INTRAW_OFS, d);
        chk("errEventCleared", 32'h0, {31'h0, d[3]});
        done("phase error");
        final_report();
    end
endmodule
`default_nettype wire
